// [integrity_calc.v]
// Running 8-bit checksum and 16-bit CRC over a byte stream
`timescale 1ns/1ps
`default_nettype none
`include "serial_msg_map.vh"

module integrity_calc (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        clr_i,
  input  wire        step_i,
  input  wire [7:0]  byte_i,
  output reg  [7:0]  cksum_o,
  output reg  [15:0] crc_o
);

  // ======================================================================
  // CRC byte step
  function [15:0] crc_step;
    input [15:0] crc_in;
    input [7:0]  data;
    reg   [15:0] c;
    begin
      c = {crc_in[7:0], crc_in[15:8]};        // Swap halves
      c = c ^ {8'h00, data};
      c = c ^ {12'h000, c[7:4]};              // Low byte shifted right by 4
      c = c ^ {c[3:0], 12'h000};              // Shift left by 12
      c = c ^ {3'h0, c[7:0], 5'h00};          // Low byte shifted left by 5
      crc_step = c;
    end
  endfunction

  // ======================================================================
  // Accumulators; clear wins so a new frame never inherits old bytes
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cksum_o <= `CKSUM_INIT;
      crc_o   <= `CRC_INIT;
    end
    else if (clr_i)
    begin
      cksum_o <= `CKSUM_INIT;
      crc_o   <= `CRC_INIT;
    end
    else if (step_i)
    begin
      cksum_o <= cksum_o ^ byte_i;
      crc_o   <= crc_step(crc_o, byte_i);
    end
  end

endmodule // integrity_calc
`default_nettype wire

// [select_word_check.v]
// Checks a stream of group-select bytes and field-select words
`timescale 1ns/1ps
`default_nettype none
`include "serial_msg_map.vh"

module select_word_check (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        valid_i,
  input  wire        first_i,
  input  wire        last_i,
  input  wire [15:0] data_i,
  output reg         done_o,
  output reg         ok_o,
  output reg  [13:0] groups_o
);

  reg        field_phase_r;
  reg  [1:0] grp_idx_r;
  reg        too_many_r;
  reg  [4:0] fld_groups_r;
  reg        fld_cont_r;
  reg        pend_r;

  // ======================================================================
  // Number of selected groups
  function [4:0] popcount;
    input [13:0] v;
    integer      i;
    begin
      popcount = 5'h00;
      for (i = 0; i < 14; i = i + 1)
        popcount = popcount + {4'h0, v[i]};
    end
  endfunction

  wire [1:0] idx     = first_i ? 2'h0 : grp_idx_r;
  wire       grp_now = first_i | ~field_phase_r;

  // ======================================================================
  // Parse items; verdict two cycles after the last item
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      field_phase_r <= 1'b0;
      grp_idx_r     <= 2'h0;
      too_many_r    <= 1'b0;
      fld_groups_r  <= 5'h00;
      fld_cont_r    <= 1'b0;
      pend_r        <= 1'b0;
      done_o        <= 1'b0;
      ok_o          <= 1'b0;
      groups_o      <= 14'h0000;
    end
    else
    begin
      done_o <= pend_r;
      pend_r <= valid_i & last_i;
      if (pend_r)
        ok_o <= field_phase_r & ~fld_cont_r
                & (fld_groups_r == popcount(groups_o))
                & ((groups_o[6:0] & `UNUSED_GRP_MASK) == 7'h00)
                & (groups_o[13:7] == 7'h00)
                & ~too_many_r;
      if (valid_i && grp_now)
      begin
        if (first_i)
        begin
          groups_o     <= 14'h0000;
          too_many_r   <= 1'b0;
          fld_groups_r <= 5'h00;
          fld_cont_r   <= 1'b0;
        end
        if (idx == 2'h0)
          groups_o[6:0] <= data_i[`GRP_SEL_WIDTH-1:0];
        else if (idx == 2'h1)
          groups_o[13:7] <= data_i[`GRP_SEL_WIDTH-1:0];
        else
          too_many_r <= 1'b1;
        if (!data_i[`GRP_EXT_BIT])
          field_phase_r <= 1'b1;
        else
        begin
          field_phase_r <= 1'b0;
          grp_idx_r     <= (idx == 2'h3) ? idx : idx + 2'h1;
        end
      end
      else if (valid_i)
      begin
        fld_cont_r <= data_i[`FLD_EXT_BIT];
        if (!data_i[`FLD_EXT_BIT])
          fld_groups_r <= fld_groups_r + 5'h01;
      end
    end
  end

endmodule // select_word_check
`default_nettype wire

// [serial_dev_model.sv]
// Behavioural model of the device on the far side of the serial link
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// Device model
module serial_dev_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       slow_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output var  logic       tx_ready_o,
  output var  logic [7:0] rx_data_o,
  output var  logic       rx_valid_o,
  output var  logic [1:0] err_o
);
  logic [7:0]  log_q[$];
  logic [15:0] acc_r, val_r;
  logic [2:0]  n_r;
  logic        in_r, dig_r, allx_r;
  wire         take = tx_valid_i && tx_ready_o && in_r;
  wire  [2:0]  w = (mode_i == 2'h2) ? 3'h4 : 3'h2;

  // One CRC step; the bench shares it for its expected frames
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = {c[7:0], c[15:8]} ^ {8'h00, d};
    r = r ^ {12'h000, r[7:4]};
    r = r ^ (r << 12);
    return r ^ {3'h0, r[7:0], 5'h00};
  endfunction

  // Idle line shows the inverse of the last byte, never a stale copy
  initial {rx_valid_o, rx_data_o} = 9'h000;
  task put(input logic [7:0] b);
    @(posedge clk_i);
    {rx_valid_o, rx_data_o} <= {1'b1, b};
    @(posedge clk_i);
    {rx_valid_o, rx_data_o} <= {1'b0, ~b};
  endtask

  // Accumulate over the body, judge at the carriage return
  always @(posedge clk_i or posedge rst_i)
    if (rst_i)
      {tx_ready_o, in_r, dig_r, err_o} <= 5'h00;
    else
    begin
      tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
      if (tx_valid_i && tx_ready_o)
        log_q.push_back(tx_data_i);
      if (tx_valid_i && tx_ready_o && tx_data_i == 8'h24)
        {in_r, dig_r, allx_r, n_r, acc_r, val_r} <= {3'b101, 3'h0, 32'h0};
      else if (take && tx_data_i == 8'h0d)
        {in_r, err_o} <= {1'b0, (mode_i == 2'h0 || n_r == w && (allx_r || val_r == acc_r)) ? 2'h0 : 2'h3};
      else if (take && !dig_r && tx_data_i == 8'h2a)
        dig_r <= 1'b1;
      else if (take && dig_r)
        {n_r, allx_r, val_r} <= {n_r + 3'h1, allx_r && tx_data_i == 8'h58,
          val_r[11:0], tx_data_i[3:0] + ((tx_data_i > 8'h39) ? 4'h9 : 4'h0)};
      else if (take)
        acc_r <= (mode_i == 2'h2) ? crc_step(acc_r, tx_data_i) : acc_r ^ {8'h00, tx_data_i};
    end
endmodule // serial_dev_model
`default_nettype wire

// [serial_msg_host.v]
// Host controller: frames commands, checks replies, vets output selections
//
// Behaviour
// - Link messages carry 8-bit checksum, 16-bit CRC, or no integrity field.
// - Checksum is XOR of bytes between dollar and asterisk, both excluded.
// - Commas in the body enter the checksum like any other byte.
// - Checksum is sent as exactly two hex characters after the asterisk.
// - CRC option is CCITT CRC16 over the message bytes.
// - CRC starts at zero; swap halves, XOR byte, shifts by 4, 12 and 5.
// - CRC is sent as exactly four hex characters after the asterisk.
// - Group byte bits 0-6 select groups, bit 7 continues to next byte.
// - Group bytes end with a byte whose continuation flag is clear.
// - Host writes zero into selection bits of groups 4, 6 and 7.
// - Host never selects the reserved groups 8 to 14.
// - Each selected group, ascending, gets one or more field-select words.
// - Field word bits 0-14 select fields, bit 15 continues to next word.
// - A group's field words end on a clear flag; next group follows.
`timescale 1ns/1ps
`default_nettype none
`include "serial_msg_map.vh"

module serial_msg_host (
  input  wire        REF_CLK_I,
  input  wire        RST_I,
  input  wire [1:0]  MODE_I,
  input  wire        BYPASS_I,
  input  wire        TX_START_I,
  input  wire [7:0]  BODY_DATA_I,
  input  wire        BODY_VALID_I,
  input  wire        BODY_LAST_I,
  output reg         BODY_READY_O,
  output reg  [7:0]  TX_DATA_O,
  output reg         TX_VALID_O,
  input  wire        TX_READY_I,
  output reg         TX_BUSY_O,
  input  wire [7:0]  RX_DATA_I,
  input  wire        RX_VALID_I,
  output reg         RX_DONE_O,
  output reg         RX_OK_O,
  output reg         RX_BYPASS_O,
  input  wire        SEL_VALID_I,
  input  wire        SEL_FIRST_I,
  input  wire        SEL_LAST_I,
  input  wire [15:0] SEL_DATA_I,
  output wire        SEL_DONE_O,
  output wire        SEL_OK_O,
  output wire [13:0] SEL_GROUPS_O
);

  // ======================================================================
  // State codes
  localparam [2:0] T_IDLE   = 3'h0;
  localparam [2:0] T_DOLLAR = 3'h1;
  localparam [2:0] T_BODY   = 3'h2;
  localparam [2:0] T_STAR   = 3'h3;
  localparam [2:0] T_HEX    = 3'h4;
  localparam [2:0] T_CR     = 3'h5;
  localparam [2:0] T_LF     = 3'h6;

  localparam [1:0] R_HUNT   = 2'h0;
  localparam [1:0] R_BODY   = 2'h1;
  localparam [1:0] R_HEX    = 2'h2;
  localparam [1:0] R_CHECK  = 2'h3;

  reg  [2:0]  tx_state_r;
  reg  [1:0]  tx_mode_r;
  reg         tx_bypass_r;
  reg  [2:0]  digit_r;
  reg         tx_clr_r;
  reg         tx_step_r;
  reg  [7:0]  tx_byte_r;
  wire [7:0]  tx_cksum;
  wire [15:0] tx_crc;

  reg  [1:0]  rx_state_r;
  reg  [1:0]  rx_mode_r;
  reg  [2:0]  rx_cnt_r;
  reg  [15:0] rx_val_r;
  reg         rx_allx_r;
  reg         rx_bad_r;
  reg         rx_clr_r;
  reg         rx_step_r;
  reg  [7:0]  rx_byte_r;
  wire [7:0]  rx_cksum;
  wire [15:0] rx_crc;

  // ======================================================================
  // Hex helpers, uppercase on transmit
  function [7:0] hex_char;
    input [3:0] nib;
    begin
      if (nib < 4'ha)
        hex_char = {4'h0, nib} + 8'h30;
      else
        hex_char = {4'h0, nib} + 8'h37;
    end
  endfunction

  function [4:0] hex_val;   // {valid, nibble}
    input [7:0] ch;
    begin
      if (ch >= 8'h30 && ch <= 8'h39)
        hex_val = {1'b1, ch[3:0]};
      else if ((ch >= 8'h41 && ch <= 8'h46) || (ch >= 8'h61 && ch <= 8'h66))
        hex_val = {1'b1, ch[3:0] + 4'h9};
      else
        hex_val = 5'h00;
    end
  endfunction

  function [2:0] digits;
    input [1:0] mode;
    begin
      digits = (mode == `MODE_CRC) ? `CRC_DIGITS : `CKSUM_DIGITS;
    end
  endfunction

  // ======================================================================
  // Integrity engines for each direction
  integrity_calc u_tx_calc (
    .clk_i   (REF_CLK_I),
    .rst_i   (RST_I),
    .clr_i   (tx_clr_r),
    .step_i  (tx_step_r),
    .byte_i  (tx_byte_r),
    .cksum_o (tx_cksum),
    .crc_o   (tx_crc)
  );

  integrity_calc u_rx_calc (
    .clk_i   (REF_CLK_I),
    .rst_i   (RST_I),
    .clr_i   (rx_clr_r),
    .step_i  (rx_step_r),
    .byte_i  (rx_byte_r),
    .cksum_o (rx_cksum),
    .crc_o   (rx_crc)
  );

  // ======================================================================
  // Selection checker; a refused config would draw an invalid-parameter reply
  select_word_check u_sel (
    .clk_i    (REF_CLK_I),
    .rst_i    (RST_I),
    .valid_i  (SEL_VALID_I),
    .first_i  (SEL_FIRST_I),
    .last_i   (SEL_LAST_I),
    .data_i   (SEL_DATA_I),
    .done_o   (SEL_DONE_O),
    .ok_o     (SEL_OK_O),
    .groups_o (SEL_GROUPS_O)
  );

  wire        slot_free = ~TX_VALID_O | TX_READY_I;
  wire [15:0] tx_value  = (tx_mode_r == `MODE_CRC) ? tx_crc : {8'h00, tx_cksum};
  wire [3:0]  tx_nib    = tx_value[{digit_r[1:0], 2'b00} +: 4];

  // ======================================================================
  // Transmit framer: dollar, body, asterisk and digits unless mode is off, CR LF
  always @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      tx_state_r   <= T_IDLE;
      tx_mode_r    <= `MODE_OFF;
      tx_bypass_r  <= 1'b0;
      digit_r      <= 3'h0;
      tx_clr_r     <= 1'b0;
      tx_step_r    <= 1'b0;
      tx_byte_r    <= 8'h00;
      BODY_READY_O <= 1'b0;
      TX_DATA_O    <= 8'h00;
      TX_VALID_O   <= 1'b0;
      TX_BUSY_O    <= 1'b0;
    end
    else
    begin
      tx_clr_r  <= 1'b0;
      tx_step_r <= 1'b0;
      if (TX_VALID_O && TX_READY_I)
        TX_VALID_O <= 1'b0;
      TX_BUSY_O <= (tx_state_r != T_IDLE) | TX_VALID_O;
      case (tx_state_r)
        T_IDLE:
        begin
          if (TX_START_I)
          begin
            tx_mode_r   <= MODE_I;
            tx_bypass_r <= BYPASS_I;
            tx_clr_r    <= 1'b1;
            TX_BUSY_O   <= 1'b1;
            tx_state_r  <= T_DOLLAR;
          end
        end
        T_DOLLAR:
        begin
          if (slot_free)
          begin
            TX_DATA_O  <= `CH_DOLLAR;              // Not summed
            TX_VALID_O <= 1'b1;
            tx_state_r <= T_BODY;
          end
        end
        T_BODY:
        begin
          if (BODY_READY_O && BODY_VALID_I)
          begin
            TX_DATA_O    <= BODY_DATA_I;
            TX_VALID_O   <= 1'b1;
            BODY_READY_O <= 1'b0;
            tx_byte_r    <= BODY_DATA_I;
            tx_step_r    <= 1'b1;                  // Commas included
            if (BODY_LAST_I)
              tx_state_r <= T_STAR;
          end
          else if (slot_free)
            BODY_READY_O <= 1'b1;
        end
        T_STAR:
        begin
          if (slot_free)
          begin
            TX_VALID_O <= 1'b1;
            if (tx_mode_r == `MODE_OFF)
            begin
              TX_DATA_O  <= `CH_CR;                // No field at all
              tx_state_r <= T_LF;
            end
            else
            begin
              TX_DATA_O  <= `CH_STAR;
              digit_r    <= digits(tx_mode_r) - 3'h1;
              tx_state_r <= T_HEX;
            end
          end
        end
        T_HEX:
        begin
          if (slot_free)
          begin
            TX_VALID_O <= 1'b1;
            TX_DATA_O  <= tx_bypass_r ? `CH_X : hex_char(tx_nib);
            digit_r    <= digit_r - 3'h1;
            if (digit_r == 3'h0)
              tx_state_r <= T_CR;
          end
        end
        T_CR:
        begin
          if (slot_free)
          begin
            TX_DATA_O  <= `CH_CR;
            TX_VALID_O <= 1'b1;
            tx_state_r <= T_LF;
          end
        end
        T_LF:
        begin
          if (slot_free)
          begin
            TX_DATA_O  <= `CH_LF;
            TX_VALID_O <= 1'b1;
            tx_state_r <= T_IDLE;
          end
        end
        default:
          tx_state_r <= T_IDLE;
      endcase
    end
  end

  wire [4:0]  rx_hex    = hex_val(RX_DATA_I);
  wire [15:0] rx_expect = (rx_mode_r == `MODE_CRC) ? rx_crc : {8'h00, rx_cksum};
  wire        rx_term   = (RX_DATA_I == `CH_CR) | (RX_DATA_I == `CH_LF);

  // ======================================================================
  // Receive checker; a stray dollar in the body restarts, so a torn reply is dropped
  always @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      rx_state_r  <= R_HUNT;
      rx_mode_r   <= `MODE_OFF;
      rx_cnt_r    <= 3'h0;
      rx_val_r    <= 16'h0000;
      rx_allx_r   <= 1'b0;
      rx_bad_r    <= 1'b0;
      rx_clr_r    <= 1'b0;
      rx_step_r   <= 1'b0;
      rx_byte_r   <= 8'h00;
      RX_DONE_O   <= 1'b0;
      RX_OK_O     <= 1'b0;
      RX_BYPASS_O <= 1'b0;
    end
    else
    begin
      rx_clr_r  <= 1'b0;
      rx_step_r <= 1'b0;
      RX_DONE_O <= 1'b0;
      case (rx_state_r)
        R_HUNT:
        begin
          if (RX_VALID_I && RX_DATA_I == `CH_DOLLAR)
          begin
            rx_clr_r   <= 1'b1;
            rx_mode_r  <= MODE_I;
            rx_state_r <= R_BODY;
          end
        end
        R_BODY:
        begin
          if (RX_VALID_I)
          begin
            if (RX_DATA_I == `CH_DOLLAR)
              rx_clr_r <= 1'b1;
            else if (RX_DATA_I == `CH_STAR || rx_term)
            begin
              if (rx_mode_r == `MODE_OFF)
              begin
                RX_DONE_O   <= 1'b1;               // Unchecked
                RX_OK_O     <= 1'b1;
                RX_BYPASS_O <= 1'b0;
                rx_state_r  <= R_HUNT;
              end
              else if (rx_term)
              begin
                RX_DONE_O   <= 1'b1;               // Field missing
                RX_OK_O     <= 1'b0;
                RX_BYPASS_O <= 1'b0;
                rx_state_r  <= R_HUNT;
              end
              else
              begin
                rx_cnt_r   <= 3'h0;
                rx_val_r   <= 16'h0000;
                rx_allx_r  <= 1'b1;
                rx_bad_r   <= 1'b0;
                rx_state_r <= R_HEX;
              end
            end
            else
            begin
              rx_byte_r <= RX_DATA_I;
              rx_step_r <= 1'b1;
            end
          end
        end
        R_HEX:
        begin
          if (RX_VALID_I)
          begin
            if (RX_DATA_I != `CH_X)
            begin
              rx_allx_r <= 1'b0;
              if (!rx_hex[4])
                rx_bad_r <= 1'b1;
            end
            rx_val_r <= {rx_val_r[11:0], rx_hex[3:0]};
            rx_cnt_r <= rx_cnt_r + 3'h1;
            if (rx_cnt_r == digits(rx_mode_r) - 3'h1)
              rx_state_r <= R_CHECK;
          end
        end
        R_CHECK:
        begin
          RX_DONE_O   <= 1'b1;
          RX_BYPASS_O <= rx_allx_r;
          RX_OK_O     <= rx_allx_r | (~rx_bad_r & (rx_val_r == rx_expect));
          rx_state_r  <= R_HUNT;
        end
        default:
          rx_state_r <= R_HUNT;
      endcase
    end
  end

endmodule // serial_msg_host
`default_nettype wire

// [serial_msg_host_asserts.sv]
// Port assertions for the serial message host controller
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// Checker
module serial_msg_host_asserts (
  input wire logic        REF_CLK_I,
  input wire logic        RST_I,
  input wire logic        TX_START_I,
  input wire logic        TX_BUSY_O,
  input wire logic [7:0]  TX_DATA_O,
  input wire logic        TX_VALID_O,
  input wire logic        TX_READY_I,
  input wire logic        BODY_VALID_I,
  input wire logic        BODY_READY_O,
  input wire logic        RX_DONE_O,
  input wire logic        RX_OK_O,
  input wire logic        RX_BYPASS_O,
  input wire logic        SEL_VALID_I,
  input wire logic        SEL_LAST_I,
  input wire logic        SEL_DONE_O,
  input wire logic        SEL_OK_O,
  input wire logic [13:0] SEL_GROUPS_O
);
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RST_I);
  // Link side: a byte stands until taken, each frame opens with a dollar sign
  tx_hold_a: assert property (TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O))
    else $error("link byte changed before it was taken");
  frame_open_a: assert property (TX_START_I && !TX_BUSY_O |-> ##[1:4] TX_DATA_O == 8'h24)
    else $error("frame did not open with a dollar sign");
  body_hold_a: assert property (BODY_READY_O && !BODY_VALID_I |=> BODY_READY_O)
    else $error("body ready dropped with no byte taken");
  // Reply verdicts are one-cycle pulses whose result stands until the next
  rx_pulse_a: assert property (RX_DONE_O |=> !RX_DONE_O)
    else $error("reply done held longer than one cycle");
  rx_stand_a: assert property (!RX_DONE_O |-> $stable(RX_OK_O) && $stable(RX_BYPASS_O))
    else $error("reply verdict moved without a done pulse");
  rx_bypass_ok_a: assert property (RX_DONE_O && RX_BYPASS_O |-> RX_OK_O)
    else $error("bypassed reply was not accepted");
  // Selection answers come two edges after the last item
  sel_answer_a: assert property (SEL_VALID_I && SEL_LAST_I |-> !SEL_DONE_O ##2 SEL_DONE_O)
    else $error("selection verdict not two edges after last item");
  sel_unused_a: assert property (SEL_DONE_O && SEL_OK_O |-> (SEL_GROUPS_O & 14'h3fe8) == 14'h0)
    else $error("accepted selection holds an unused group");
  cover property (RX_DONE_O && RX_BYPASS_O);
  cover property (SEL_DONE_O && SEL_OK_O);
  cover property (TX_VALID_O && TX_READY_I && TX_DATA_O == 8'h0a);
endmodule // serial_msg_host_asserts

bind serial_msg_host serial_msg_host_asserts chk (.*);
`default_nettype wire

// [serial_msg_map.vh]
// Constants shared by the serial message host controller files
`ifndef SERIAL_MSG_MAP_VH
`define SERIAL_MSG_MAP_VH

// ======================================================================
// Framing characters
`define CH_DOLLAR      8'h24
`define CH_STAR        8'h2a
`define CH_CR          8'h0d
`define CH_LF          8'h0a
`define CH_X           8'h58

// ======================================================================
// Integrity modes
`define MODE_OFF       2'h0
`define MODE_CKSUM     2'h1
`define MODE_CRC       2'h2

// ======================================================================
// Integrity widths, start values and digit counts
`define CKSUM_INIT     8'h00
`define CRC_INIT       16'h0000
`define CKSUM_DIGITS   3'h2
`define CRC_DIGITS     3'h4

// ======================================================================
// Selection word layout
`define GRP_EXT_BIT    7
`define FLD_EXT_BIT    15
`define GRP_SEL_WIDTH  7
`define UNUSED_GRP_MASK 7'h68

`endif

// [test_serial_msg_check_output_select.sv]
// Self-checking testbench for the serial message host controller
`timescale 1ns/1ps
`default_nettype none
// ======================================================================
// Bench top
module test_serial_msg_check_output_select;
  logic        REF_CLK_I, RST_I, BYPASS_I, TX_START_I, BODY_VALID_I, BODY_LAST_I;
  logic        TX_READY_I, RX_VALID_I, SEL_VALID_I, SEL_FIRST_I, SEL_LAST_I, slow;
  logic [1:0]  MODE_I, dev_err;
  logic [7:0]  BODY_DATA_I, TX_DATA_O, RX_DATA_I;
  logic [15:0] SEL_DATA_I;
  logic [13:0] SEL_GROUPS_O;
  logic        BODY_READY_O, TX_VALID_O, TX_BUSY_O, RX_DONE_O, RX_OK_O, RX_BYPASS_O;
  logic        SEL_DONE_O, SEL_OK_O;
  logic [7:0]  fq[$];
  int          err_total, check_count, rx_cnt;

  serial_msg_host dut (.*);
  serial_dev_model dev (.clk_i(REF_CLK_I), .rst_i(RST_I), .mode_i(MODE_I), .slow_i(slow),
    .tx_data_i(TX_DATA_O), .tx_valid_i(TX_VALID_O), .tx_ready_o(TX_READY_I),
    .rx_data_o(RX_DATA_I), .rx_valid_o(RX_VALID_I), .err_o(dev_err));

  // 40 MHz clock
  initial
  begin
    REF_CLK_I = 1'b0;
    forever #12.5 REF_CLK_I = ~REF_CLK_I;
  end

  // Count reply pulses so a verdict that lands mid-frame is not missed
  always @(posedge REF_CLK_I)
    if (RX_DONE_O === 1'b1) rx_cnt <= rx_cnt + 1;

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) err_total++;
    if (seen !== exp) $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
  endtask

  // Expected frame: dollar, body, then, unless mode 0, star and upper-case digits or X
  function automatic void mk(input string b, input logic [1:0] m, input logic x, bad);
    logic [15:0] c, v;
    logic [7:0]  s;
    int          n;
    fq = {8'h24};
    s = 8'h00;
    c = 16'h0000;
    for (int i = 0; i < b.len(); i++)
    begin
      fq.push_back(b[i]);
      s = s ^ b[i];
      c = dev.crc_step(c, b[i]);
    end
    v = (m == 2'h2) ? c ^ {15'h0, bad} : {s ^ {7'h0, bad}, 8'h00};
    n = (m == 2'h2) ? 4 : (m == 2'h0) ? 0 : 2;
    if (n > 0) fq.push_back(8'h2a);
    for (int k = 0; k < n; k++, v = v << 4)
      fq.push_back(x ? 8'h58 : {4'h3, v[15:12]} + ((v[15:12] > 4'h9) ? 8'h07 : 8'h00));
    fq = {fq, 8'h0d, 8'h0a};
  endfunction

  // Send one command and compare every byte the device received
  task automatic t_tx(input logic [1:0] m, input logic x, s);
    string b = "WRG,75,1,16,01,0029";
    int    i = 0;
    int    k = 0;
    int    b0;
    logic  r;
    mk(b, m, x, 1'b0);
    b0 = dev.log_q.size();
    @(negedge REF_CLK_I);
    {MODE_I, BYPASS_I, slow, TX_START_I} = {m, x, s, 1'b1};
    @(negedge REF_CLK_I);
    TX_START_I = 1'b0;
    chk(TX_BUSY_O, 1'b1);
    while (i < b.len() && k++ < 300)
    begin
      {BODY_DATA_I, BODY_VALID_I, BODY_LAST_I} = {b[i], 1'b1, i == b.len() - 1};
      r = BODY_READY_O;
      @(negedge REF_CLK_I);
      i = i + (r === 1'b1);
    end
    {BODY_VALID_I, BODY_LAST_I} = 2'b00;
    for (k = 0; k < 300 && TX_BUSY_O !== 1'b0; k++) @(negedge REF_CLK_I);
    repeat (3) @(negedge REF_CLK_I);
    chk(dev.log_q.size() - b0, fq.size());
    foreach (fq[j]) chk(dev.log_q[b0 + j], fq[j]);
    chk(dev_err, 2'h0);
  endtask

  // Device sends a reply; one verdict pulse is expected
  task automatic t_rx(input logic [1:0] m, input logic x, bad, mix, ok, byp);
    int c0;
    mk("RG,8,+1.5", m, x, bad);
    if (mix) fq[fq.size() - 4] = 8'h58;
    if (m == 2'h3) fq[fq.size() - 3] = fq[fq.size() - 3] | 8'h20; // Lower-case letter digit
    @(negedge REF_CLK_I);
    MODE_I = m;
    c0 = rx_cnt;
    foreach (fq[i]) dev.put(fq[i]);
    repeat (4) @(negedge REF_CLK_I);
    chk(rx_cnt - c0, 1);
    chk(RX_OK_O, ok);
    chk(RX_BYPASS_O, byp);
  endtask

  // Selection items one per cycle, verdict read once done rises
  task automatic t_sel(input logic [15:0] q[$], input logic ok, input logic [13:0] g);
    int k;
    foreach (q[i])
    begin
      @(negedge REF_CLK_I);
      {SEL_VALID_I, SEL_FIRST_I, SEL_LAST_I, SEL_DATA_I} = {1'b1, i == 0, i == q.size() - 1, q[i]};
    end
    @(negedge REF_CLK_I);
    {SEL_VALID_I, SEL_FIRST_I, SEL_LAST_I} = 3'b000;
    for (k = 0; k < 8 && SEL_DONE_O !== 1'b1; k++) @(negedge REF_CLK_I);
    chk(SEL_DONE_O, 1'b1);
    chk(SEL_OK_O, ok);
    if (ok) chk(SEL_GROUPS_O, g);
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {RST_I, MODE_I, BODY_DATA_I, SEL_DATA_I} = {1'b1, 26'h0};
    {BYPASS_I, TX_START_I, BODY_VALID_I, BODY_LAST_I, SEL_VALID_I} = 5'h00;
    {SEL_FIRST_I, SEL_LAST_I, slow} = 3'h0;
    repeat (4) @(negedge REF_CLK_I);
    RST_I = 1'b0;
    for (int m = 0; m < 4; m++) t_tx(m[1:0], 1'b0, m[0]);
    t_tx(2'h1, 1'b1, 1'b0);
    t_tx(2'h2, 1'b1, 1'b1);
    t_rx(2'h1, 0, 0, 0, 1, 0);
    t_rx(2'h1, 0, 1, 0, 0, 0);
    t_rx(2'h1, 1, 0, 0, 1, 1);
    t_rx(2'h1, 0, 0, 1, 0, 0);
    t_rx(2'h3, 0, 0, 0, 1, 0);
    t_rx(2'h2, 0, 0, 0, 1, 0);
    t_rx(2'h2, 0, 1, 0, 0, 0);
    t_rx(2'h2, 1, 0, 0, 1, 1);
    t_rx(2'h0, 0, 0, 0, 1, 0);
    t_sel({16'h0005, 16'h0001, 16'h0002}, 1'b1, 14'h0005);
    t_sel({16'h0001, 16'h8001, 16'h0001}, 1'b1, 14'h0001);
    t_sel({16'h0005, 16'h0001}, 1'b0, 14'h0);
    t_sel({16'h0008, 16'h0001}, 1'b0, 14'h0);
    t_sel({16'h0081, 16'h0001, 16'h0001}, 1'b0, 14'h0);
    t_sel({16'h0081, 16'h0000, 16'h0001}, 1'b1, 14'h0001);
    t_sel({16'h0081, 16'h0080, 16'h0000, 16'h0001}, 1'b0, 14'h0);
    t_sel({16'h0001, 16'h8001}, 1'b0, 14'h0);
    wrap_up();
  end

  // Watchdog at 20000 cycles, well beyond the fewer than one thousand cycles the tests need
  initial
  begin
    #500000;
    err_total++;
    wrap_up();
  end
endmodule // test_serial_msg_check_output_select
`default_nettype wire
